// File: rtl/lsfb_params.svh
// Constants for the load-side feedback blend block
`ifndef LSFB_PARAMS_SVH
`define LSFB_PARAMS_SVH
`define LSFB_FILT_RESET 10'h00a
`define LSFB_FILT_FULL 10'h3e8
`define LSFB_BLEND_SHIFT 10
`define LSFB_SEL_SEMI 2'h0
`define LSFB_SEL_CLOSED 2'h1
`define LSFB_SEL_SWITCH 2'h2
`endif

// File: rtl/lsfb_pkg.sv
// Types for the load-side feedback blend block
package lsfb_pkg;
   typedef enum logic [1:0]
   {
      LSFB_SEMI = 2'h0,
      LSFB_DUAL = 2'h1,
      LSFB_FULL = 2'h2
   } lsfb_mode_t;
endpackage

// File: rtl/lsfb_blend.sv
// Load-side feedback tracking and dual feedback blend
// Behaviour
// - Count load-side pulses when clock-enabled, the encoder moves and no fault.
// - Clear within-revolution position when home mark or Z-phase passes.
// - Matching polarity: CCW motor raises position, CW lowers it.
// - Mismatched polarity: position moves opposite to motor direction.
// - Motor and load counts advance in gear numerator/denominator ratio.
// - Filter setting defaults to ten after reset.
// - Larger filter setting weights load-side feedback more heavily.
// - Enabled: settings 1 to 999 give dual, 1000 gives fully closed.
// - Switchable mode: command off gives semi, on follows the filter setting as when enabled.
`timescale 1ns/100ps
`include "lsfb_params.svh"
module lsfb_blend #(
   parameter int CW = 32,
   parameter int PW = 24,
   parameter int GW = 16
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic load_step,
   input wire logic load_up,
   input wire logic load_home,
   input wire logic load_fault,
   input wire logic motor_step,
   input wire logic motor_ccw,
   input wire logic polarity_invert,
   input wire logic [1:0] closed_loop_function_select,
   input wire logic closed_cmd,
   input wire logic filt_wr,
   input wire logic [9:0] filt_wdata,
   input wire logic [GW-1:0] closed_loop_gear_numerator,
   input wire logic [GW-1:0] closed_loop_gear_denominator,
   input wire logic [CW-1:0] motor_pos,
   output logic [CW-1:0] load_cum_q,
   output logic [CW-1:0] motor_cum_q,
   output logic [CW-1:0] motor_in_load_q,
   output logic [PW-1:0] load_rev_pos_q,
   output logic [9:0] dual_feedback_filter_setting_q,
   output logic [1:0] mode_q,
   output logic [CW-1:0] blend_pos_q
);
   // ==========================================================
   // Direction and mode decode
   // ==========================================================
   logic load_inc;
   logic [GW:0] gear_acc_q;
   logic [GW:0] gear_acc_d;
   lsfb_pkg::lsfb_mode_t mode_d;
   logic [CW-1:0] blend_d;

   // Polarity setting flips the counting sense of the load encoder
   // direction sense select
   assign load_inc = load_up ^ polarity_invert;

   // Mode from function select, switch command and filter setting
   always_comb
   begin
      mode_d = lsfb_pkg::LSFB_SEMI;
      if ((closed_loop_function_select == `LSFB_SEL_CLOSED) ||
          (closed_loop_function_select == `LSFB_SEL_SWITCH && closed_cmd))
      begin
         if (dual_feedback_filter_setting_q >= `LSFB_FILT_FULL)
            mode_d = lsfb_pkg::LSFB_FULL;
         else if (dual_feedback_filter_setting_q != 10'h000)
            mode_d = lsfb_pkg::LSFB_DUAL;
      end
   end

   // ==========================================================
   // Load-side counters
   // ==========================================================
   // Cumulative load count; a fault freezes it rather than guess
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         load_cum_q <= '0;
      else if (clk_en && load_step && !load_fault)
      begin
         if (load_inc)
            load_cum_q <= load_cum_q + 1'b1;
         else
            load_cum_q <= load_cum_q - 1'b1;
      end
   end

   // Within-revolution position, home mark takes priority
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         load_rev_pos_q <= '0;
      else if (clk_en)
      begin
         if (load_home)
            load_rev_pos_q <= '0;
         else if (load_step && !load_fault)
         begin
            if (load_inc)
               load_rev_pos_q <= load_rev_pos_q + 1'b1;
            else
               load_rev_pos_q <= load_rev_pos_q - 1'b1;
         end
      end
   end

   // ==========================================================
   // Electronic gear: motor pulses scaled into load pulses
   // ==========================================================
   // Bresenham accumulator: each motor pulse adds denominator,
   // each numerator overflow yields one load-equivalent pulse
   always_comb
   begin
      gear_acc_d = gear_acc_q;
      if (motor_step)
         gear_acc_d = gear_acc_q + {1'b0, closed_loop_gear_denominator};
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         gear_acc_q <= '0;
         motor_cum_q <= '0;
         motor_in_load_q <= '0;
      end
      else if (clk_en && motor_step)
      begin
         if (motor_ccw)
            motor_cum_q <= motor_cum_q + 1'b1;
         else
            motor_cum_q <= motor_cum_q - 1'b1;
         if (gear_acc_d >= {1'b0, closed_loop_gear_numerator})
         begin
            gear_acc_q <= gear_acc_d - {1'b0, closed_loop_gear_numerator};
            if (motor_ccw)
               motor_in_load_q <= motor_in_load_q + 1'b1;
            else
               motor_in_load_q <= motor_in_load_q - 1'b1;
         end
         else
            gear_acc_q <= gear_acc_d;
      end
   end

   // ==========================================================
   // Filter setting and blend
   // ==========================================================
   // Writable filter setting; configurer keeps it under gain/2
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         dual_feedback_filter_setting_q <= `LSFB_FILT_RESET;
      else if (clk_en && filt_wr)
         dual_feedback_filter_setting_q <= filt_wdata;
   end

   // Weighted blend: motor + (load - motor) * setting / 1024
   // Power-of-two divide trades exact 1/1000 for no divider
   always_comb
   begin
      logic [CW+10:0] diff;
      logic [CW-1:0] delta;
      // Sign comes from the difference, not from the load count alone
      delta = load_cum_q - motor_pos;
      diff = '0;
      blend_d = motor_pos;
      case (mode_d)
         lsfb_pkg::LSFB_FULL: blend_d = load_cum_q;
         lsfb_pkg::LSFB_DUAL:
         begin
            diff = $signed({{11{delta[CW-1]}}, delta})
                   * $signed({1'b0, dual_feedback_filter_setting_q});
            blend_d = motor_pos + diff[CW+9:`LSFB_BLEND_SHIFT];
         end
         default: blend_d = motor_pos;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mode_q <= 2'h0;
         blend_pos_q <= '0;
      end
      else if (clk_en)
      begin
         mode_q <= mode_d;
         blend_pos_q <= blend_d;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   home_clear_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && load_home |=> load_rev_pos_q == '0)
      else $error("position not cleared by home mark");
   load_count_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && load_step && !load_fault && load_inc
      |=> load_cum_q == $past(load_cum_q) + 1'b1)
      else $error("load count did not advance");
   fault_hold_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      load_fault |=> load_cum_q == $past(load_cum_q))
      else $error("load count moved during fault");
   enable_freeze_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      !clk_en |=> $stable(load_cum_q) && $stable(load_rev_pos_q))
      else $error("load counts moved while disabled");
   pos_dir_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && load_step && !load_fault && !load_home && !load_inc
      |=> load_rev_pos_q == $past(load_rev_pos_q) - 1'b1)
      else $error("position moved the wrong way");
   filt_reset_a: assert property (
      @(posedge clk_sys)
      $past(reset) |-> dual_feedback_filter_setting_q == `LSFB_FILT_RESET)
      else $error("filter default not ten");
   full_mode_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && closed_loop_function_select == `LSFB_SEL_CLOSED
      && dual_feedback_filter_setting_q == `LSFB_FILT_FULL
      |=> mode_q == lsfb_pkg::LSFB_FULL)
      else $error("setting 1000 not fully closed");
   dual_mode_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && closed_loop_function_select == `LSFB_SEL_CLOSED
      && dual_feedback_filter_setting_q != 10'h000
      && dual_feedback_filter_setting_q < `LSFB_FILT_FULL
      |=> mode_q == lsfb_pkg::LSFB_DUAL)
      else $error("setting below 1000 not dual feedback");
   switch_semi_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      clk_en && closed_loop_function_select == `LSFB_SEL_SWITCH && !closed_cmd
      |=> mode_q == lsfb_pkg::LSFB_SEMI)
      else $error("switch off not semi closed");
   gear_hold_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      !motor_step |=> motor_cum_q == $past(motor_cum_q)
      && motor_in_load_q == $past(motor_in_load_q))
      else $error("gear counts moved without motor step");
endmodule

// File: testbench/lsfb_enc_model.sv
// Load-side encoder model: count pulses, direction and home mark
`timescale 1ns/100ps
module lsfb_enc_model (
   input wire logic clk_sys,
   output logic load_step,
   output logic load_up,
   output logic load_home
);
   initial
   begin
      load_step = 1'b0;
      load_up = 1'b0;
      load_home = 1'b0;
   end
   // =========================================
   // Motion
   // Home mark rides on the last count of a move
   // Direction is inverted when idle so a stale level is never trusted
   task automatic move(input int n, input logic up, input logic home);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk_sys);
         load_step <= 1'b1;
         load_up <= up;
         load_home <= home && (i == n - 1);
      end
      @(negedge clk_sys);
      load_step <= 1'b0;
      load_up <= ~up;
      load_home <= 1'b0;
   endtask
endmodule

// File: testbench/lsfb_tb.sv
// Self-checking bench for the load-side feedback blend block
`timescale 1ns/100ps
module tb;
   logic clk_sys, reset, clk_en, load_step, load_up, load_home, load_fault;
   logic motor_step, motor_ccw, polarity_invert, closed_cmd, filt_wr;
   logic [1:0] sel;
   logic [9:0] filt_wdata;
   logic [15:0] num, den;
   logic [31:0] motor_pos, load_cum_q, motor_cum_q, motor_in_load_q, blend_q;
   logic [31:0] c0, b0;
   logic [23:0] rev_q;
   logic [9:0] filt_q;
   logic [1:0] mode_q;
   int errors, total_checks, cyc;
   lsfb_enc_model enc (.clk_sys(clk_sys), .load_step(load_step),
      .load_up(load_up), .load_home(load_home));
   lsfb_blend uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
      .load_step(load_step), .load_up(load_up), .load_home(load_home),
      .load_fault(load_fault), .motor_step(motor_step),
      .motor_ccw(motor_ccw), .polarity_invert(polarity_invert),
      .closed_loop_function_select(sel), .closed_cmd(closed_cmd),
      .filt_wr(filt_wr), .filt_wdata(filt_wdata),
      .closed_loop_gear_numerator(num), .closed_loop_gear_denominator(den),
      .motor_pos(motor_pos), .load_cum_q(load_cum_q),
      .motor_cum_q(motor_cum_q), .motor_in_load_q(motor_in_load_q),
      .load_rev_pos_q(rev_q), .dual_feedback_filter_setting_q(filt_q),
      .mode_q(mode_q), .blend_pos_q(blend_q));
   // =========================================
   // Clock and hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Ceiling well above the hundred or so cycles the tests need
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         results();
      end
   end
   // =========================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic setf(input logic [9:0] v);
      @(negedge clk_sys);
      filt_wr = 1'b1;
      filt_wdata = v;
      @(negedge clk_sys);
      filt_wr = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // =========================================
   // Tests
   initial
   begin
      {reset, clk_en, load_fault, motor_step, motor_ccw} = 5'h19;
      {polarity_invert, closed_cmd, filt_wr, filt_wdata} = 13'h0000;
      sel = 2'h1;
      num = 16'h0004;
      den = 16'h0001;
      motor_pos = 32'h00000000;
      repeat (12) @(negedge clk_sys);
      reset = 1'b0;
      chk("filter", 32'h0000000a, 32'(filt_q));
      chk("load cum", 32'h00000000, load_cum_q);
      $display("test reset done");
      enc.move(20, 1'b1, 1'b0);
      chk("load cum", 32'h00000014, load_cum_q);
      chk("rev pos", 32'h00000014, 32'(rev_q));
      setf(10'h064);
      b0 = blend_q;
      setf(10'h384);
      chk("blend rises", 32'h1, 32'(blend_q > b0));
      chk("blend dual", 32'h00000011, blend_q);
      polarity_invert = 1'b1;
      enc.move(3, 1'b1, 1'b0);
      chk("rev pos", 32'h00000011, 32'(rev_q));
      polarity_invert = 1'b0;
      enc.move(2, 1'b0, 1'b0);
      chk("rev pos", 32'h0000000f, 32'(rev_q));
      $display("test direction done");
      c0 = load_cum_q;
      load_fault = 1'b1;
      enc.move(5, 1'b1, 1'b0);
      chk("fault hold", c0, load_cum_q);
      load_fault = 1'b0;
      clk_en = 1'b0;
      enc.move(2, 1'b1, 1'b0);
      clk_en = 1'b1;
      chk("freeze", c0, load_cum_q);
      enc.move(4, 1'b1, 1'b1);
      chk("home rev", 32'h00000000, 32'(rev_q));
      chk("home cum", c0 + 32'h4, load_cum_q);
      $display("test fault and home done");
      motor_step = 1'b1;
      repeat (9) @(negedge clk_sys);
      motor_step = 1'b0;
      @(negedge clk_sys);
      chk("motor cum", 32'h00000009, motor_cum_q);
      chk("gear", 32'h00000002, motor_in_load_q);
      $display("test gear done");
      // Motor ahead of load so the dual blend sees a negative difference
      motor_pos = 32'h00000040;
      for (int i = 0; i < 6; i++)
      begin
         sel = (i < 2) ? 2'h1 : (i == 2) ? 2'h0 : (i == 5) ? 2'h3 : 2'h2;
         closed_cmd = (i >= 4);
         setf(i == 1 ? 10'h1f4 : 10'h3e8);
         chk("mode", (i == 1) ? 32'(lsfb_pkg::LSFB_DUAL) :
            (i == 0 || i == 4) ? 32'(lsfb_pkg::LSFB_FULL) :
            32'(lsfb_pkg::LSFB_SEMI), 32'(mode_q));
         chk("blend", (i == 1) ? 32'h0000002a :
            (i == 0 || i == 4) ? 32'h00000013 : 32'h00000040, blend_q);
      end
      $display("test mode done");
      results();
   end
endmodule
